// ### design/code_page_pkg.sv
// Constants for the code page reverse map
package code_page_pkg;
   localparam int PAGE_COUNT = 64;
   localparam int PHYS_W = 8;
   localparam int VIRT_W = 16;
   localparam int FLAG_W = 3;
   localparam logic [3:0] VIRT_INDEX_WIDTH = 4'h8;
   localparam logic [8:0] PAGE_BYTES = 9'h100;
   localparam int PAGE_SHIFT = 8;
   localparam int FLAG_USABLE = 0;
   localparam int FLAG_BUSY = 1;
   localparam int FLAG_PROT = 2;
   localparam logic [FLAG_W-1:0] FLAGS_BUSY = 3'h2;
   localparam logic [FLAG_W-1:0] FLAGS_USABLE = 3'h1;
   localparam logic [FLAG_W-1:0] FLAGS_PROT = 3'h4;
   localparam logic [11:0] ADDR_COMMAND = 12'h140;
   localparam logic [11:0] ADDR_RESULT = 12'h144;
   localparam logic [11:0] ADDR_UPLOAD_INDEX = 12'h180;
   localparam logic [11:0] ADDR_UPLOAD_DATA = 12'h184;
   localparam logic [11:0] ADDR_UPLOAD_VIRT = 12'h188;
   localparam logic [11:0] ADDR_CAPS = 12'h108;
   localparam logic [11:0] ADDR_CAPS2 = 12'h10c;
   localparam int CMD_LSB = 24;
   localparam int PARAM_W = 24;
   localparam logic [1:0] CMD_INVALIDATE = 2'h1;
   localparam logic [1:0] CMD_PHYS = 2'h2;
   localparam logic [1:0] CMD_VIRT = 2'h3;
   localparam int RES_VIRT_LSB = 8;
   localparam int RES_FLAGS_LSB = 24;
   localparam int RES_MULTI = 30;
   localparam int RES_NONE = 31;
   localparam int CAPS2_VW_LSB = 16;
   localparam int AUTOINC_BIT = 24;
   localparam logic [7:0] WORD_FIRST = 8'h00;
   localparam logic [7:0] WORD_LAST = 8'hfc;
   localparam logic [15:0] WORD_STEP = 16'h0004;
   localparam logic [7:0] OPC_READ = 8'hfe;
   localparam logic [7:0] OPC_INVAL = 8'hf9;
   localparam logic [3:0] SUB_PHYS = 4'h2;
   localparam logic [3:0] SUB_VIRT = 4'h3;
   localparam logic [3:0] SUB_INVAL = 4'h8;
   localparam logic [3:0] REASON_NOHIT = 4'ha;
   localparam logic [3:0] REASON_MULTI = 4'hb;
endpackage : code_page_pkg

// ### design/code_page_match.sv
// One translation cell compare for the virtual lookup
`timescale 1ns/100ps
module code_page_match #(
   parameter int VIRT_W = 16
) (
   input wire logic [2:0] flags_i,
   input wire logic [VIRT_W-1:0] virt_i,
   input wire logic [VIRT_W-1:0] key_i,
   input wire logic [VIRT_W-1:0] mask_i,
   output logic hit_o
);
   // Valid cell with equal masked virtual index
   assign hit_o = (|flags_i) && ((virt_i & mask_i) == key_i);
endmodule : code_page_match

// ### design/code_page_reverse_map.sv
// Reverse page table for code memory with fetch checking
//
// Function
// - 256-byte pages, one cell per page
// - Flags: usable, busy, protected bits
// - Cell valid when any flag set
// - Virtual access searches cells, flags errors
// - Capability words give page count, index width
// - 24-bit parameter, 32-bit lookup results
// - Invalidate clears cell unless protected
// - Physical lookup result layout
// - Virtual lookup compares masked shifted address
// - Virtual result: last phys, ORed flags
// - Bit 30 multihit, bit 31 no hit
// - Command register runs selected operation
// - Result register holds last command lookup
// - Opcode fe sub 2/3 lookups
// - Opcode f9 sub 8 invalidates
// - Fetch lookup traps with 0xa or 0xb
// - Usable completes, busy stalls and retries
// - Protected only requests authenticated switch
// - Code loaded through upload window
// - Word zero marks busy, last word usable
// - Auto-increment advances upload address
`timescale 1ns/100ps
module code_page_reverse_map #(
   parameter int PAGE_COUNT = code_page_pkg::PAGE_COUNT,
   parameter logic [3:0] VIRT_INDEX_WIDTH = code_page_pkg::VIRT_INDEX_WIDTH
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // Register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   // Processor instruction port
   input wire logic insn_valid_i,
   input wire logic [7:0] insn_opcode_i,
   input wire logic [3:0] insn_subop_i,
   input wire logic [31:0] insn_src_i,
   output logic insn_done_o,
   output logic [31:0] insn_dst_o,
   // Fetch check port
   input wire logic fetch_valid_i,
   input wire logic [23:0] fetch_addr_i,
   input wire logic [23:0] program_counter_i,
   output logic fetch_ok_o,
   output logic [7:0] fetch_phys_o,
   output logic fetch_stall_o,
   output logic fetch_trap_o,
   output logic [3:0] trap_reason_o,
   output logic [23:0] trap_pc_o,
   output logic auth_switch_o,
   // Code memory write port
   output logic code_we_o,
   output logic [15:0] code_addr_o,
   output logic [31:0] code_wdata_o
);
   localparam int VW = code_page_pkg::VIRT_W;
   localparam int PW = code_page_pkg::PHYS_W;
   localparam int FW = code_page_pkg::FLAG_W;

   typedef struct packed {
      logic [PAGE_COUNT-1:0][FW-1:0] flags;
      logic [PAGE_COUNT-1:0][VW-1:0] virt;
      logic [31:0] command;
      logic [31:0] result;
      logic [31:0] upload_index;
      logic [VW-1:0] upload_virt;
      logic [31:0] rdata;
      logic insn_done;
      logic [31:0] insn_dst;
      logic fetch_ok;
      logic [PW-1:0] fetch_phys;
      logic fetch_stall;
      logic fetch_trap;
      logic [3:0] trap_reason;
      logic [23:0] trap_pc;
      logic auth_switch;
      logic code_we;
      logic [15:0] code_addr;
      logic [31:0] code_wdata;
   } state_s;

   state_s st_reg;
   state_s st_next;

   // ==========================================================
   // Virtual lookup compare
   // ==========================================================
   logic [VW-1:0] vmask;
   logic [VW-1:0] op_key;
   logic [VW-1:0] fetch_key;
   logic [PAGE_COUNT-1:0] op_hit;
   logic [PAGE_COUNT-1:0] fetch_hit;
   logic [23:0] op_param;
   logic op_is_virt;

   assign vmask = VW'((32'h1 << VIRT_INDEX_WIDTH) - 32'h1);
   assign op_key = VW'(op_param >> code_page_pkg::PAGE_SHIFT) & vmask;
   assign fetch_key = VW'(fetch_addr_i >> code_page_pkg::PAGE_SHIFT) & vmask;

   genvar gi;
   generate
      for (gi = 0; gi < PAGE_COUNT; gi++) begin : g_cell
         code_page_match #(.VIRT_W(VW)) u_op (
            .flags_i(st_reg.flags[gi]),
            .virt_i(st_reg.virt[gi]),
            .key_i(op_key),
            .mask_i(vmask),
            .hit_o(op_hit[gi])
         );
         code_page_match #(.VIRT_W(VW)) u_fetch (
            .flags_i(st_reg.flags[gi]),
            .virt_i(st_reg.virt[gi]),
            .key_i(fetch_key),
            .mask_i(vmask),
            .hit_o(fetch_hit[gi])
         );
      end
   endgenerate

   function automatic logic [31:0] virt_result(
      input logic [PAGE_COUNT-1:0] hit,
      input logic [PAGE_COUNT-1:0][FW-1:0] flags
   );
      logic [PW-1:0] phys;
      logic [FW-1:0] f;
      int n;
      logic [31:0] r;
      phys = '0;
      f = '0;
      n = 0;
      for (int i = 0; i < PAGE_COUNT; i++) begin
         if (hit[i]) begin
            phys = PW'(i);
            f = f | flags[i];
            n = n + 1;
         end
      end
      r = '0;
      r[PW-1:0] = phys;
      r[code_page_pkg::RES_FLAGS_LSB +: FW] = f;
      r[code_page_pkg::RES_MULTI] = (n > 1);
      r[code_page_pkg::RES_NONE] = (n == 0);
      return r;
   endfunction : virt_result

   function automatic logic [31:0] phys_result(
      input logic [FW-1:0] f,
      input logic [VW-1:0] v
   );
      logic [31:0] r;
      r = '0;
      r[code_page_pkg::RES_VIRT_LSB +: VW] = v;
      r[code_page_pkg::RES_FLAGS_LSB +: FW] = f;
      return r;
   endfunction : phys_result

   // ==========================================================
   // Next state
   // ==========================================================
   logic [31:0] op_virt_res;
   logic [31:0] fetch_res;
   logic [1:0] op_sel;
   logic op_from_reg;
   logic [PW-1:0] op_page;

   always_comb begin
      op_from_reg = reg_wr_i && (reg_addr_i == code_page_pkg::ADDR_COMMAND);
      op_param = insn_src_i[code_page_pkg::PARAM_W-1:0];
      op_sel = 2'h0;
      if (op_from_reg) begin
         op_param = reg_wdata_i[code_page_pkg::PARAM_W-1:0];
         op_sel = reg_wdata_i[code_page_pkg::CMD_LSB +: 2];
      end else if (insn_valid_i) begin
         if (insn_opcode_i == code_page_pkg::OPC_READ) begin
            if (insn_subop_i == code_page_pkg::SUB_PHYS) begin
               op_sel = code_page_pkg::CMD_PHYS;
            end else if (insn_subop_i == code_page_pkg::SUB_VIRT) begin
               op_sel = code_page_pkg::CMD_VIRT;
            end
         end else if (insn_opcode_i == code_page_pkg::OPC_INVAL &&
                      insn_subop_i == code_page_pkg::SUB_INVAL) begin
            op_sel = code_page_pkg::CMD_INVALIDATE;
         end
      end
      op_is_virt = (op_sel == code_page_pkg::CMD_VIRT);
      op_page = op_param[PW-1:0];
   end

   assign op_virt_res = virt_result(op_hit, st_reg.flags);
   assign fetch_res = virt_result(fetch_hit, st_reg.flags);

   logic [31:0] op_res;
   logic page_ok;
   logic [PW-1:0] up_page;
   logic [7:0] up_word;
   logic cells_changed;

   always_comb begin
      st_next = st_reg;
      st_next.insn_done = 1'b0;
      st_next.code_we = 1'b0;
      st_next.fetch_ok = 1'b0;
      st_next.fetch_trap = 1'b0;
      st_next.auth_switch = 1'b0;
      page_ok = (32'(op_page) < 32'(PAGE_COUNT));
      cells_changed = 1'b0;

      // Lookup and invalidate operations
      op_res = '0;
      if (op_sel == code_page_pkg::CMD_PHYS && page_ok) begin
         op_res = phys_result(st_reg.flags[op_page], st_reg.virt[op_page]);
      end else if (op_is_virt) begin
         op_res = op_virt_res;
      end
      if (op_sel == code_page_pkg::CMD_INVALIDATE && page_ok &&
          !st_reg.flags[op_page][code_page_pkg::FLAG_PROT]) begin
         st_next.flags[op_page] = '0;
         st_next.virt[op_page] = '0;
         cells_changed = 1'b1;
      end
      if (op_from_reg) begin
         st_next.command = reg_wdata_i;
         if (op_sel == code_page_pkg::CMD_PHYS || op_is_virt) begin
            st_next.result = op_res;
         end
      end else if (insn_valid_i) begin
         st_next.insn_done = 1'b1;
         st_next.insn_dst = op_res;
      end

      // Upload window
      up_page = st_reg.upload_index[code_page_pkg::PAGE_SHIFT +: PW];
      up_word = {st_reg.upload_index[7:2], 2'b00};
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            code_page_pkg::ADDR_UPLOAD_INDEX: begin
               st_next.upload_index = reg_wdata_i;
            end
            code_page_pkg::ADDR_UPLOAD_VIRT: begin
               st_next.upload_virt = reg_wdata_i[VW-1:0];
            end
            code_page_pkg::ADDR_UPLOAD_DATA: begin
               st_next.code_we = 1'b1;
               st_next.code_addr = {st_reg.upload_index[15:2], 2'b00};
               st_next.code_wdata = reg_wdata_i;
               if (32'(up_page) < 32'(PAGE_COUNT)) begin
                  if (up_word == code_page_pkg::WORD_FIRST) begin
                     st_next.virt[up_page] = st_reg.upload_virt;
                     st_next.flags[up_page] = code_page_pkg::FLAGS_BUSY;
                     cells_changed = 1'b1;
                  end else if (up_word == code_page_pkg::WORD_LAST) begin
                     st_next.flags[up_page] =
                        code_page_pkg::FLAGS_USABLE;
                     cells_changed = 1'b1;
                  end
               end
               if (st_reg.upload_index[code_page_pkg::AUTOINC_BIT]) begin
                  st_next.upload_index[15:0] =
                     st_reg.upload_index[15:0] +
                     code_page_pkg::WORD_STEP;
               end
            end
            default: begin
            end
         endcase
      end

      // Register reads
      st_next.rdata = '0;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            code_page_pkg::ADDR_COMMAND: st_next.rdata = st_reg.command;
            code_page_pkg::ADDR_RESULT: st_next.rdata = st_reg.result;
            code_page_pkg::ADDR_UPLOAD_INDEX:
               st_next.rdata = st_reg.upload_index;
            code_page_pkg::ADDR_UPLOAD_VIRT:
               st_next.rdata = 32'(st_reg.upload_virt);
            code_page_pkg::ADDR_CAPS:
               st_next.rdata = 32'(PAGE_COUNT);
            code_page_pkg::ADDR_CAPS2:
               st_next.rdata = 32'(VIRT_INDEX_WIDTH) <<
                  code_page_pkg::CAPS2_VW_LSB;
            default: st_next.rdata = '0;
         endcase
      end

      // Fetch check
      if (fetch_valid_i && (!st_reg.fetch_stall || cells_changed ||
                            st_reg.fetch_stall)) begin
         st_next.fetch_stall = 1'b0;
         if (fetch_res[code_page_pkg::RES_NONE]) begin
            st_next.fetch_trap = 1'b1;
            st_next.trap_reason = code_page_pkg::REASON_NOHIT;
            st_next.trap_pc = program_counter_i;
         end else if (fetch_res[code_page_pkg::RES_MULTI]) begin
            st_next.fetch_trap = 1'b1;
            st_next.trap_reason = code_page_pkg::REASON_MULTI;
            st_next.trap_pc = program_counter_i;
         end else if (fetch_res[code_page_pkg::RES_FLAGS_LSB +
                                code_page_pkg::FLAG_USABLE]) begin
            st_next.fetch_ok = 1'b1;
            st_next.fetch_phys = fetch_res[PW-1:0];
         end else if (fetch_res[code_page_pkg::RES_FLAGS_LSB +
                                code_page_pkg::FLAG_BUSY]) begin
            st_next.fetch_stall = 1'b1;
         end else begin
            st_next.auth_switch = 1'b1;
         end
      end else if (!fetch_valid_i) begin
         st_next.fetch_stall = 1'b0;
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata_o = st_reg.rdata;
   assign insn_done_o = st_reg.insn_done;
   assign insn_dst_o = st_reg.insn_dst;
   assign fetch_ok_o = st_reg.fetch_ok;
   assign fetch_phys_o = st_reg.fetch_phys;
   assign fetch_stall_o = st_reg.fetch_stall;
   assign fetch_trap_o = st_reg.fetch_trap;
   assign trap_reason_o = st_reg.trap_reason;
   assign trap_pc_o = st_reg.trap_pc;
   assign auth_switch_o = st_reg.auth_switch;
   assign code_we_o = st_reg.code_we;
   assign code_addr_o = st_reg.code_addr;
   assign code_wdata_o = st_reg.code_wdata;
endmodule : code_page_reverse_map

// ### verif/code_page_checker.sv
// Port-level assertions for the code page reverse map
`timescale 1ns/100ps
module code_page_checker #(
   parameter int PAGE_COUNT = 64,
   parameter logic [3:0] VIRT_INDEX_WIDTH = 4'h8
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic insn_valid_i,
   input wire logic insn_done_o,
   input wire logic fetch_valid_i,
   input wire logic [23:0] program_counter_i,
   input wire logic fetch_ok_o,
   input wire logic fetch_stall_o,
   input wire logic fetch_trap_o,
   input wire logic [3:0] trap_reason_o,
   input wire logic [23:0] trap_pc_o,
   input wire logic auth_switch_o,
   input wire logic code_we_o,
   input wire logic [31:0] code_wdata_o
);
   // ==========================================================
   // Shadow of the command register
   logic [31:0] cmd_reg;
   logic cmd_wr;
   assign cmd_wr = reg_wr_i && reg_addr_i == code_page_pkg::ADDR_COMMAND;
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cmd_reg <= 32'h00000000;
      end else if (cmd_wr) begin
         cmd_reg <= reg_wdata_i;
      end
   end
   // ==========================================================
   // Assertions
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   cmd_readback_a: assert property (reg_rd_i && reg_addr_i ==
      code_page_pkg::ADDR_COMMAND |=> reg_rdata_o == $past(cmd_reg))
      else $error("command readback wrong");
   rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data not zero when idle");
   caps_width_a: assert property (reg_rd_i && reg_addr_i ==
      code_page_pkg::ADDR_CAPS2 |=> reg_rdata_o[19:16] == VIRT_INDEX_WIDTH)
      else $error("index width field wrong");
   caps_count_a: assert property (reg_rd_i && reg_addr_i ==
      code_page_pkg::ADDR_CAPS |=> reg_rdata_o[8:0] == 9'(PAGE_COUNT))
      else $error("page count field wrong");
   insn_done_a: assert property (insn_valid_i && !cmd_wr |=>
      insn_done_o)
      else $error("instruction not completed");
   done_cause_a: assert property (insn_done_o |-> $past(insn_valid_i))
      else $error("done without instruction");
   fetch_answer_a: assert property (fetch_valid_i |=>
      fetch_ok_o || fetch_trap_o || auth_switch_o || fetch_stall_o)
      else $error("fetch left unanswered");
   one_answer_a: assert property ($onehot0({fetch_ok_o,
      fetch_trap_o, auth_switch_o, fetch_stall_o}))
      else $error("several fetch answers at once");
   trap_reason_a: assert property (fetch_trap_o |->
      trap_reason_o == 4'ha || trap_reason_o == 4'hb)
      else $error("bad trap reason");
   trap_pc_a: assert property (fetch_trap_o |->
      trap_pc_o == $past(program_counter_i))
      else $error("trap pc wrong");
   upload_write_a: assert property (reg_wr_i && reg_addr_i ==
      code_page_pkg::ADDR_UPLOAD_DATA |=> code_we_o &&
      code_wdata_o == $past(reg_wdata_i))
      else $error("upload write not passed on");
   trap_c: cover property (fetch_trap_o);
   stall_c: cover property (fetch_stall_o ##1 fetch_ok_o);
   upload_c: cover property (code_we_o);
endmodule : code_page_checker

bind code_page_reverse_map code_page_checker #(.PAGE_COUNT(PAGE_COUNT),
   .VIRT_INDEX_WIDTH(VIRT_INDEX_WIDTH)) i_chk (.ref_clk_i(ref_clk_i),
   .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .insn_valid_i(insn_valid_i),
   .insn_done_o(insn_done_o), .fetch_valid_i(fetch_valid_i),
   .program_counter_i(program_counter_i), .fetch_ok_o(fetch_ok_o),
   .fetch_stall_o(fetch_stall_o), .fetch_trap_o(fetch_trap_o),
   .trap_reason_o(trap_reason_o), .trap_pc_o(trap_pc_o),
   .auth_switch_o(auth_switch_o), .code_we_o(code_we_o),
   .code_wdata_o(code_wdata_o));

// ### verif/fetch_unit_model.sv
// Instruction fetch unit model for the fetch check port
`timescale 1ns/100ps
module fetch_unit_model (
   input wire logic ref_clk_i,
   input wire logic ok_i,
   input wire logic trap_i,
   input wire logic auth_i,
   output logic valid_o,
   output logic [23:0] addr_o,
   output logic [23:0] pc_o
);
   initial begin
      valid_o = 1'b0;
      addr_o = 24'h000000;
      pc_o = 24'h000000;
   end
   // ==========================================================
   // Holds a fetch until ok, trap or auth switch, or 400 cycles, then releases it
   task automatic fetch(input logic [23:0] a, input int gap,
         output logic [2:0] kind, output int waits);
      repeat (gap) @(negedge ref_clk_i);
      valid_o = 1'b1;
      addr_o = a;
      pc_o = a;
      waits = 0;
      do begin
         @(negedge ref_clk_i);
         waits++;
      end while (!(ok_i || trap_i || auth_i) && waits < 400);
      kind = {auth_i, trap_i, ok_i};
      valid_o = 1'b0;
      addr_o = ~a;
      pc_o = ~a;
   endtask : fetch
endmodule : fetch_unit_model

// ### verif/tb_top.sv
// Self-checking bench for the code page reverse map
`timescale 1ns/100ps
module tb_top;
   logic ref_clk_i, rst_b_i, reg_wr_i, reg_rd_i, insn_valid_i;
   logic fetch_valid_i, insn_done_o, fetch_ok_o, fetch_stall_o;
   logic fetch_trap_o, auth_switch_o, code_we_o;
   logic [11:0] reg_addr_i;
   logic [31:0] reg_wdata_i, insn_src_i, reg_rdata_o, insn_dst_o;
   logic [31:0] code_wdata_o, res;
   logic [7:0] insn_opcode_i, fetch_phys_o;
   logic [3:0] insn_subop_i, trap_reason_o;
   logic [23:0] fetch_addr_i, program_counter_i, trap_pc_o;
   logic [15:0] code_addr_o;
   logic [2:0] kind;
   int waits;
   int failures = 0;
   int compares = 0;

   code_page_reverse_map i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .insn_valid_i(insn_valid_i), .insn_opcode_i(insn_opcode_i),
      .insn_subop_i(insn_subop_i), .insn_src_i(insn_src_i),
      .insn_done_o(insn_done_o), .insn_dst_o(insn_dst_o),
      .fetch_valid_i(fetch_valid_i), .fetch_addr_i(fetch_addr_i),
      .program_counter_i(program_counter_i), .fetch_ok_o(fetch_ok_o),
      .fetch_phys_o(fetch_phys_o), .fetch_stall_o(fetch_stall_o),
      .fetch_trap_o(fetch_trap_o), .trap_reason_o(trap_reason_o),
      .trap_pc_o(trap_pc_o), .auth_switch_o(auth_switch_o),
      .code_we_o(code_we_o), .code_addr_o(code_addr_o),
      .code_wdata_o(code_wdata_o));
   fetch_unit_model i_fetch (.ref_clk_i(ref_clk_i), .ok_i(fetch_ok_o),
      .trap_i(fetch_trap_o), .auth_i(auth_switch_o), .valid_o(fetch_valid_i),
      .addr_o(fetch_addr_i), .pc_o(program_counter_i));

   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   // ==========================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(negedge ref_clk_i);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(negedge ref_clk_i);
      reg_wr_i = 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(negedge ref_clk_i);
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      @(negedge ref_clk_i);
      reg_rd_i = 1'b0;
      d = reg_rdata_o;
   endtask : rd
   task automatic cmd(input logic [1:0] c, input logic [23:0] p);
      wr(code_page_pkg::ADDR_COMMAND, {6'h00, c, p});
      rd(code_page_pkg::ADDR_RESULT, res);
   endtask : cmd
   task automatic insn(input logic [7:0] op, input logic [3:0] sub,
         input logic [31:0] src);
      @(negedge ref_clk_i);
      insn_valid_i = 1'b1;
      insn_opcode_i = op;
      insn_subop_i = sub;
      insn_src_i = src;
      @(negedge ref_clk_i);
      insn_valid_i = 1'b0;
      check({31'h0, insn_done_o}, 32'h1);
   endtask : insn
   task automatic load(input logic [7:0] pg, input logic [7:0] vp,
         input int lo, input int hi);
      wr(code_page_pkg::ADDR_UPLOAD_INDEX, {16'h0100, pg, 8'(lo * 4)});
      wr(code_page_pkg::ADDR_UPLOAD_VIRT, {24'h000000, vp});
      for (int i = lo; i <= hi; i++) begin
         wr(code_page_pkg::ADDR_UPLOAD_DATA, 32'(i));
         check({16'h0, code_addr_o}, {16'h0, pg, 8'(i * 4)});
         check(code_wdata_o, 32'(i));
      end
   endtask : load
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      cmd(2'h2, 24'h000000);
      check(res, 32'h00000000);
      rd(code_page_pkg::ADDR_CAPS, res);
      check({23'h0, res[8:0]}, 32'h00000040);
      rd(code_page_pkg::ADDR_CAPS2, res);
      check({28'h0, res[19:16]}, 32'h00000008);
      rd(12'h1f0, res);
      check(res, 32'h00000000);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_upload();
      load(8'h02, 8'h05, 0, 0);
      cmd(2'h2, 24'h000002);
      check(res, 32'h02000500);
      load(8'h02, 8'h05, 1, 63);
      cmd(2'h2, 24'h000002);
      check(res, 32'h01000500);
      rd(code_page_pkg::ADDR_COMMAND, res);
      check(res, 32'h02000002);
      $display("t_upload done");
   endtask : t_upload
   task automatic t_lookup();
      cmd(2'h3, 24'h010523);
      check(res, 32'h01000002);
      cmd(2'h3, 24'h000700);
      check(res, 32'h80000000);
      load(8'h03, 8'h05, 0, 63);
      cmd(2'h3, 24'h0005ff);
      check(res, 32'h41000003);
      insn(8'hfe, 4'h3, 32'h00000500);
      check(insn_dst_o, 32'h41000003);
      insn(8'hfe, 4'h2, 32'h00000003);
      check(insn_dst_o, 32'h01000500);
      rd(code_page_pkg::ADDR_RESULT, res);
      check(res, 32'h41000003);
      $display("t_lookup done");
   endtask : t_lookup
   task automatic t_fetch();
      i_fetch.fetch(24'h000500, 0, kind, waits);
      check({29'h0, kind}, 32'h2);
      check({28'h0, trap_reason_o}, 32'hb);
      check({8'h0, trap_pc_o}, 32'h00000500);
      insn(8'hf9, 4'h8, 32'h00000003);
      cmd(2'h2, 24'h000003);
      check(res, 32'h00000000);
      i_fetch.fetch(24'h000540, 2, kind, waits);
      check({29'h0, kind}, 32'h1);
      check({24'h0, fetch_phys_o}, 32'h2);
      i_fetch.fetch(24'h000740, 1, kind, waits);
      check({28'h0, trap_reason_o}, 32'ha);
      $display("t_fetch done");
   endtask : t_fetch
   task automatic t_stall();
      load(8'h04, 8'h09, 0, 0);
      fork
         i_fetch.fetch(24'h000910, 1, kind, waits);
         begin
            repeat (4) @(negedge ref_clk_i);
            check({31'h0, fetch_stall_o}, 32'h1);
            load(8'h04, 8'h09, 1, 63);
         end
      join
      check({29'h0, kind}, 32'h1);
      check({24'h0, fetch_phys_o}, 32'h4);
      cmd(2'h1, 24'h000004);
      cmd(2'h2, 24'h000004);
      check(res, 32'h00000000);
      $display("t_stall done");
   endtask : t_stall
   // ==========================================================
   // Verdict
   task automatic close_out();
      $display("Counts: %0d compares, %0d failures", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out
   initial begin
      rst_b_i = 1'b0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 12'h000;
      reg_wdata_i = 32'h00000000;
      insn_valid_i = 1'b0;
      insn_opcode_i = 8'h00;
      insn_subop_i = 4'h0;
      insn_src_i = 32'h00000000;
      repeat (10) @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      t_reset();
      t_upload();
      t_lookup();
      t_fetch();
      t_stall();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      failures++;
      close_out();
   end
endmodule : tb_top
